// *** design/hub_pkg.sv ***
package hub_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_GPI = 8'h04;
    localparam logic [7:0] OFS_LOCK = 8'h08;
    localparam logic [7:0] OFS_HWPROT = 8'h0c;
    // Status register fields
    localparam int STS_GPI_LSB = 0;
    localparam int STS_ID_LSB = 5;
    localparam int STS_MUX_BIT = 9;
    localparam int STS_RDARR_BIT = 10;
    // Array geometry
    localparam int BLOCKS = 16;
    localparam int ADDR_BITS = 20;
    localparam int ROW_BITS = 11;
    localparam int COL_BITS = 9;
    localparam int BLK_LSB = 16;
    localparam logic [3:0] TOP_BLOCK = 4'hf;
    localparam logic [3:0] BOOT_ID = 4'h0;
    // Lock reset value, read-array command code, word transfer size
    localparam logic [15:0] LOCK_RESET = 16'hffff;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // Hub clock rate in MHz
    localparam int HUB_CLK_MHZ = 33;

    typedef enum logic [2:0] {
        MX_IDLE = 3'b001,
        MX_LOW = 3'b010,
        MX_ISSUE = 3'b100
    } mux_state_type;
endpackage : hub_pkg

// *** design/pin_sampler.sv ***
`timescale 1ns/1ps
module pin_sampler #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    // Pin levels
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] prev,
    output logic [WIDTH-1:0] rise
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= '1;
        end else if (en) begin
            prev <= din;
        end
    end

    assign rise = din & ~prev;
endmodule : pin_sampler

// *** design/hub_strap_protect_mux_port.sv ***
`timescale 1ns/1ps
module hub_strap_protect_mux_port
    import hub_pkg::*;
(
    // Clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Board straps and protect pins
    input wire logic init_n,
    input wire logic interface_select,
    input wire logic [3:0] part_select_strap,
    input wire logic [4:0] board_gp_inputs,
    input wire logic top_block_lock_n,
    input wire logic write_protect_n,
    // Multiplexed-address pins
    input wire logic row_col_sel,
    input wire logic [ROW_BITS-1:0] addr_pins,
    input wire logic write_strobe_n,
    input wire logic output_gate_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    // Hub cycle requests
    input wire logic hub_req,
    input wire logic [3:0] hub_req_id,
    input wire logic hub_req_write,
    input wire logic [ADDR_BITS-1:0] hub_req_addr,
    input wire logic [7:0] hub_req_data,
    output logic [7:0] hub_read_data,
    output logic hub_oe_n,
    // Array read contents
    input wire logic [7:0] array_rdata,
    // Command interface
    output logic cmd_valid,
    output logic [ADDR_BITS-1:0] cmd_addr,
    output logic [7:0] cmd_data,
    output logic cmd_alter_refused,
    output logic read_array_mode
);

    ////////////////////////////////////////////////////////////////////////
    // Reset, configuration capture

    logic sys_rst_n;
    logic cfg_taken;
    logic mux_mode;
    logic [3:0] strap_id;

    assign sys_rst_n = hresetn & init_n;

    // Straps caught on the first enabled edge after release
    always_ff @(posedge hclk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            cfg_taken <= 1'b0;
            mux_mode <= 1'b0;
            strap_id <= BOOT_ID;
        end else if (clk_en && !cfg_taken) begin
            cfg_taken <= 1'b1;
            mux_mode <= interface_select;
            strap_id <= part_select_strap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Protection

    logic [BLOCKS-1:0] lock;

    function automatic logic refuse_alter(input logic [3:0] blk, input logic [BLOCKS-1:0] lk,
                                          input logic top_n, input logic wp_n);
        logic hw;
        hw = 1'b0;
        if (blk == TOP_BLOCK) begin
            hw = ~top_n;
        end else begin
            hw = ~wp_n;
        end
        refuse_alter = hw | lk[blk];
    endfunction : refuse_alter

    ////////////////////////////////////////////////////////////////////////
    // Multiplexed-address write path

    logic ws_prev;
    logic ws_rise;
    logic [ROW_BITS-1:0] row_addr;
    logic [COL_BITS-1:0] col_addr;
    mux_state_type mx_state;
    logic mux_capture;
    logic hub_match;
    logic hub_wr_match;
    logic capture_now;
    logic [ADDR_BITS-1:0] new_addr;
    logic [7:0] new_data;

    pin_sampler #(
        .WIDTH(1)
    ) u_strobe (
        .clk(hclk),
        .rst_n(sys_rst_n),
        .en(clk_en),
        .din(write_strobe_n),
        .prev(ws_prev),
        .rise(ws_rise)
    );

    always_ff @(posedge hclk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            row_addr <= '0;
            col_addr <= '0;
        end else if (clk_en && mux_mode) begin
            if (row_col_sel) begin
                row_addr <= addr_pins;
            end else begin
                col_addr <= addr_pins[COL_BITS-1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            mx_state <= MX_IDLE;
        end else if (clk_en) begin
            case (mx_state)
                MX_IDLE: begin
                    if (cfg_taken && mux_mode && !write_strobe_n) begin
                        mx_state <= MX_LOW;
                    end
                end
                MX_LOW: begin
                    if (ws_rise) begin
                        mx_state <= MX_ISSUE;
                    end
                end
                MX_ISSUE: begin
                    mx_state <= MX_IDLE;
                end
                default: begin
                    mx_state <= MX_IDLE;
                end
            endcase
        end
    end

    assign mux_capture = (mx_state == MX_LOW) && ws_rise;
    assign hub_match = cfg_taken && !mux_mode && hub_req && (hub_req_id == strap_id);
    assign hub_wr_match = hub_match && hub_req_write;
    assign capture_now = clk_en && (mux_capture || hub_wr_match);
    assign new_addr = mux_capture ? {col_addr, row_addr} : hub_req_addr;
    assign new_data = mux_capture ? data_in : hub_req_data;

    // Write address and data held until the next capture; cmd_valid pulses for one cycle
    always_ff @(posedge hclk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            cmd_valid <= 1'b0;
            cmd_addr <= '0;
            cmd_data <= '0;
            cmd_alter_refused <= 1'b0;
        end else if (clk_en) begin
            cmd_valid <= capture_now;
            if (capture_now) begin
                cmd_addr <= new_addr;
                cmd_data <= new_data;
                cmd_alter_refused <= refuse_alter(new_addr[BLK_LSB+3:BLK_LSB], lock,
                                                  top_block_lock_n, write_protect_n);
            end
        end
    end

    always_ff @(posedge hclk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            read_array_mode <= 1'b1;
        end else if (clk_en && capture_now) begin
            read_array_mode <= (new_data == CMD_READ_ARRAY);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read drivers

    logic mux_drive;

    assign mux_drive = cfg_taken && mux_mode && !output_gate_n && write_strobe_n;

    always_ff @(posedge hclk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            data_oe_n <= 1'b1;
            data_out <= '0;
        end else if (clk_en) begin
            data_oe_n <= ~mux_drive;
            data_out <= mux_drive ? array_rdata : 8'h00;
        end
    end

    // Hub logic clocked by hclk standing in for the shared bus clock
    always_ff @(posedge hclk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            hub_oe_n <= 1'b1;
            hub_read_data <= '0;
        end else if (clk_en) begin
            hub_oe_n <= ~(hub_match && !hub_req_write);
            hub_read_data <= (hub_match && !hub_req_write) ? array_rdata : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite register slave

    logic ahb_wr;
    logic [7:0] ahb_wr_addr;
    logic ahb_take;
    logic lock_wr;
    logic [BLOCKS-1:0] lock_view;
    logic [BLOCKS-1:0] hwprot_view;
    logic [31:0] next_hrdata;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ahb_take = hready && hsel && htrans[1];
    assign lock_wr = ahb_wr && (ahb_wr_addr == OFS_LOCK);
    assign lock_view = lock_wr ? hwdata[BLOCKS-1:0] : lock;

    always_comb begin
        hwprot_view = '0;
        for (int i = 0; i < BLOCKS; i++) begin
            hwprot_view[i] = refuse_alter(4'(i), '0, top_block_lock_n, write_protect_n);
        end
    end

    always_comb begin
        next_hrdata = 32'h0000_0000;
        if (haddr[7:0] == OFS_STATUS && haddr[31:8] == 24'h000000) begin
            next_hrdata[STS_GPI_LSB +: 5] = board_gp_inputs;
            next_hrdata[STS_ID_LSB +: 4] = strap_id;
            next_hrdata[STS_MUX_BIT] = mux_mode;
            next_hrdata[STS_RDARR_BIT] = read_array_mode;
        end else if (haddr[7:0] == OFS_GPI && haddr[31:8] == 24'h000000) begin
            next_hrdata[4:0] = board_gp_inputs;
        end else if (haddr[7:0] == OFS_LOCK && haddr[31:8] == 24'h000000) begin
            next_hrdata[BLOCKS-1:0] = lock_view;
        end else if (haddr[7:0] == OFS_HWPROT && haddr[31:8] == 24'h000000) begin
            next_hrdata[BLOCKS-1:0] = hwprot_view;
        end
    end

    always_ff @(posedge hclk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            ahb_wr <= 1'b0;
            ahb_wr_addr <= '0;
            hrdata <= '0;
        end else if (clk_en) begin
            if (hready) begin
                ahb_wr <= ahb_take && hwrite && (hsize == HSIZE_WORD) && (haddr[31:8] == 24'h000000);
                ahb_wr_addr <= haddr[7:0];
                if (ahb_take && !hwrite) begin
                    hrdata <= next_hrdata;
                end
            end
        end
    end

    // Only software writes and reset (hresetn or init_n) move the lock bits
    always_ff @(posedge hclk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            lock <= LOCK_RESET;
        end else if (clk_en && lock_wr) begin
            lock <= hwdata[BLOCKS-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking @(posedge hclk); endclocking
    default disable iff (!sys_rst_n);

    top_hw_refuse_a: assert property (capture_now && new_addr[19:16] == TOP_BLOCK && !top_block_lock_n
        |=> cmd_valid && cmd_alter_refused) else $error("top block write not refused");
    top_reg_lock_a: assert property (capture_now && new_addr[19:16] == TOP_BLOCK && top_block_lock_n
        |=> cmd_alter_refused == $past(lock[TOP_BLOCK])) else $error("top block lock wrong");
    low_hw_refuse_a: assert property (capture_now && new_addr[19:16] != TOP_BLOCK && !write_protect_n
        |=> cmd_valid && cmd_alter_refused) else $error("lower block write not refused");
    low_reg_lock_a: assert property (capture_now && new_addr[19:16] != TOP_BLOCK && write_protect_n
        |=> cmd_alter_refused == $past(lock[new_addr[19:16]])) else $error("lower lock wrong");
    lock_only_sw_a: assert property ($changed(lock) |-> $past(lock_wr && clk_en))
        else $error("lock changed without software write");
    row_latch_a: assert property (clk_en && mux_mode && row_col_sel |=> row_addr == $past(addr_pins))
        else $error("row half not latched");
    strobe_capture_a: assert property (clk_en && mux_capture
        |=> cmd_valid && cmd_data == $past(data_in) && cmd_addr == $past({col_addr, row_addr}))
        else $error("strobe capture wrong");
    pending_hold_a: assert property ($changed(cmd_addr) || $changed(cmd_data) |-> $past(capture_now))
        else $error("pending write altered");
    gate_drive_a: assert property (!data_oe_n |-> $past(mux_drive) && $past(!output_gate_n))
        else $error("data driven without output gate");
    float_zero_a: assert property (data_oe_n |-> data_out == 8'h00)
        else $error("data not idle while disabled");
    read_data_a: assert property (clk_en && mux_drive |=> !data_oe_n && data_out == $past(array_rdata))
        else $error("read data wrong");
    hub_id_a: assert property (!hub_oe_n |-> $past(hub_req && hub_req_id == strap_id && !mux_mode))
        else $error("hub answered foreign cycle");

    mux_write_c: cover property (mux_capture ##1 cmd_valid && !cmd_alter_refused);
    hub_read_c: cover property (hub_match && !hub_req_write ##1 !hub_oe_n);
    refused_c: cover property (cmd_valid && cmd_alter_refused);
    mux_read_c: cover property (!data_oe_n [*3]);
endmodule : hub_strap_protect_mux_port

// *** tb/board_model.sv ***
`timescale 1ns/1ps
module board_model
    import hub_pkg::*;
(
    // Clock
    input wire logic hclk,
    // Multiplexed pins
    output logic row_col_sel,
    output logic [ROW_BITS-1:0] addr_pins,
    output logic write_strobe_n,
    output logic output_gate_n,
    output logic [7:0] data_in,
    // Hub requests
    output logic hub_req,
    output logic [3:0] hub_req_id,
    output logic hub_req_write,
    output logic [ADDR_BITS-1:0] hub_req_addr,
    output logic [7:0] hub_req_data
);
    initial begin
        row_col_sel = 1'b0;
        addr_pins = '0;
        write_strobe_n = 1'b1;
        output_gate_n = 1'b1;
        data_in = 8'h00;
        hub_req = 1'b0;
        hub_req_id = 4'h0;
        hub_req_write = 1'b0;
        hub_req_addr = '0;
        hub_req_data = 8'h00;
    end
    ////////////////////////////////////////
    task automatic mux_write(input logic [COL_BITS-1:0] col, input logic [ROW_BITS-1:0] row, input logic [7:0] d);
        @(posedge hclk);
        row_col_sel <= 1'b1;
        addr_pins <= row;
        @(posedge hclk);
        row_col_sel <= 1'b0;
        addr_pins <= {2'b00, col};
        data_in <= d;
        write_strobe_n <= 1'b0;
        repeat (2) @(posedge hclk);
        write_strobe_n <= 1'b1;
        @(posedge hclk);
        // Released pins show the inverse
        addr_pins <= ~addr_pins;
        data_in <= ~d;
    endtask : mux_write
    task automatic hub_cycle(input logic [3:0] id, input logic wr, input logic [ADDR_BITS-1:0] a, input logic [7:0] d);
        @(posedge hclk);
        hub_req <= 1'b1;
        hub_req_id <= id;
        hub_req_write <= wr;
        hub_req_addr <= a;
        hub_req_data <= d;
        @(posedge hclk);
        hub_req <= 1'b0;
        hub_req_id <= ~id;
        hub_req_addr <= ~a;
        hub_req_data <= ~d;
    endtask : hub_cycle
    task automatic gate(input logic v);
        @(posedge hclk);
        output_gate_n <= v;
    endtask : gate
endmodule : board_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
    import hub_pkg::*;
;
    logic hclk, hresetn, clk_en, hsel, hwrite, init_n, interface_select, top_block_lock_n, write_protect_n;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] part_select_strap, hub_req_id;
    logic [4:0] board_gp_inputs;
    logic [7:0] array_rdata, data_out, hub_read_data, cmd_data, data_in, hub_req_data;
    logic [ROW_BITS-1:0] addr_pins;
    logic [ADDR_BITS-1:0] hub_req_addr, cmd_addr;
    logic hreadyout, hresp, data_oe_n, hub_oe_n, cmd_valid, cmd_alter_refused, read_array_mode;
    logic row_col_sel, write_strobe_n, output_gate_n, hub_req, hub_req_write;
    int n_mismatch, checked, i;
    hub_strap_protect_mux_port dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .init_n(init_n),
        .interface_select(interface_select), .part_select_strap(part_select_strap),
        .board_gp_inputs(board_gp_inputs), .top_block_lock_n(top_block_lock_n),
        .write_protect_n(write_protect_n), .row_col_sel(row_col_sel), .addr_pins(addr_pins),
        .write_strobe_n(write_strobe_n), .output_gate_n(output_gate_n), .data_in(data_in),
        .data_out(data_out), .data_oe_n(data_oe_n), .hub_req(hub_req), .hub_req_id(hub_req_id),
        .hub_req_write(hub_req_write), .hub_req_addr(hub_req_addr), .hub_req_data(hub_req_data),
        .hub_read_data(hub_read_data), .hub_oe_n(hub_oe_n), .array_rdata(array_rdata),
        .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .cmd_alter_refused(cmd_alter_refused), .read_array_mode(read_array_mode));
    board_model brd (.hclk(hclk), .row_col_sel(row_col_sel), .addr_pins(addr_pins),
        .write_strobe_n(write_strobe_n), .output_gate_n(output_gate_n), .data_in(data_in),
        .hub_req(hub_req), .hub_req_id(hub_req_id), .hub_req_write(hub_req_write),
        .hub_req_addr(hub_req_addr), .hub_req_data(hub_req_data));
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk1(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask : chk1
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0, r);
        chk(nm, e, r);
        chk1("hresp", 1'b0, hresp);
    endtask : rchk
    task automatic wait_cmd;
        for (i = 0; i < 6 && cmd_valid !== 1'b1; i++) @(posedge hclk);
        chk1("cmd_valid", 1'b1, cmd_valid);
        @(posedge hclk);
        chk1("cmd_valid", 1'b0, cmd_valid);
    endtask : wait_cmd
    task automatic quiet;
        repeat (4) begin
            @(posedge hclk);
            chk1("cmd_valid", 1'b0, cmd_valid);
            chk1("hub_oe_n", 1'b1, hub_oe_n);
        end
    endtask : quiet
    task automatic prot(input logic t, input logic w, input logic [15:0] lk, input logic [3:0] b,
            input logic [7:0] d, input logic e);
        ahb(1'b1, OFS_LOCK, {16'h0, lk}, r);
        top_block_lock_n <= t;
        write_protect_n <= w;
        brd.mux_write({b, 5'h0a}, 11'h5a5, d);
        wait_cmd;
        chk("cmd_addr", {12'h0, b, 5'h0a, 11'h5a5}, {12'h0, cmd_addr});
        chk("cmd_data", {24'h0, d}, {24'h0, cmd_data});
        chk1("refused", e, cmd_alter_refused);
        chk1("read_array", d == CMD_READ_ARRAY, read_array_mode);
        chk1("data_oe_n", 1'b1, data_oe_n);
    endtask : prot
    task automatic conclude;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    ////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        repeat (5000) @(posedge hclk);
        n_mismatch++;
        conclude;
    end
    initial begin
        n_mismatch = 0;
        checked = 0;
        hresetn = 1'b0;
        init_n = 1'b1;
        clk_en = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
        interface_select = 1'b1;
        part_select_strap = 4'h1;
        board_gp_inputs = 5'h15;
        top_block_lock_n = 1'b0;
        write_protect_n = 1'b1;
        array_rdata = 8'h00;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        rchk("status", OFS_STATUS, {21'h0, 1'b1, 1'b1, 4'h1, 5'h15});
        rchk("gpi", OFS_GPI, 32'h15);
        board_gp_inputs <= 5'h0a;
        rchk("gpi", OFS_GPI, 32'h0a);
        rchk("lock", OFS_LOCK, 32'hffff);
        rchk("hwprot", OFS_HWPROT, 32'h8000);
        ahb(1'b1, OFS_HWPROT, 32'h0, r);
        rchk("hwprot", OFS_HWPROT, 32'h8000);
        rchk("unmapped", 8'h40, 32'h0);
        prot(1'b0, 1'b1, 16'h0000, 4'hf, 8'h40, 1'b1);
        prot(1'b1, 1'b1, 16'h0000, 4'hf, 8'hff, 1'b0);
        prot(1'b1, 1'b1, 16'h8000, 4'hf, 8'h20, 1'b1);
        prot(1'b1, 1'b0, 16'h0000, 4'he, 8'h40, 1'b1);
        prot(1'b0, 1'b1, 16'h0000, 4'h3, 8'hff, 1'b0);
        prot(1'b1, 1'b1, 16'h0008, 4'h3, 8'h60, 1'b1);
        write_protect_n <= 1'b0;
        rchk("hwprot", OFS_HWPROT, 32'h7fff);
        rchk("lock", OFS_LOCK, 32'h0008);
        array_rdata <= 8'hc3;
        chk1("data_oe_n", 1'b1, data_oe_n);
        brd.gate(1'b0);
        for (i = 0; i < 4 && data_oe_n !== 1'b0; i++) @(posedge hclk);
        chk("data_out", 32'hc3, {24'h0, data_out});
        brd.gate(1'b1);
        for (i = 0; i < 4 && data_oe_n !== 1'b1; i++) @(posedge hclk);
        chk("data_out", 32'h0, {24'h0, data_out});
        init_n <= 1'b0;
        interface_select <= 1'b0;
        part_select_strap <= BOOT_ID;
        repeat (3) @(posedge hclk);
        init_n <= 1'b1;
        repeat (3) @(posedge hclk);
        rchk("status", OFS_STATUS, {21'h0, 1'b1, 1'b0, 4'h0, 5'h0a});
        rchk("lock", OFS_LOCK, 32'hffff);
        array_rdata <= 8'h96;
        brd.hub_cycle(4'h0, 1'b0, 20'h0, 8'h00);
        for (i = 0; i < 4 && hub_oe_n !== 1'b0; i++) @(posedge hclk);
        chk("hub_data", 32'h96, {24'h0, hub_read_data});
        brd.hub_cycle(4'h1, 1'b0, 20'h0, 8'h00);
        quiet;
        brd.hub_cycle(4'h2, 1'b1, 20'h30000, 8'h11);
        quiet;
        brd.hub_cycle(4'h0, 1'b1, 20'hf1234, 8'h5a);
        wait_cmd;
        chk("cmd_addr", 32'hf1234, {12'h0, cmd_addr});
        chk1("refused", 1'b1, cmd_alter_refused);
        clk_en <= 1'b0;
        brd.hub_cycle(4'h0, 1'b1, 20'h01234, 8'h77);
        @(posedge hclk);
        chk1("cmd_valid", 1'b0, cmd_valid);
        chk("cmd_addr", 32'hf1234, {12'h0, cmd_addr});
        clk_en <= 1'b1;
        interface_select <= 1'b1;
        brd.mux_write(9'h1ff, 11'h0, 8'h11);
        quiet;
        conclude;
    end
endmodule : tb_top
